/* File: verilog/dcp_decoder.sv */
// Channel configuration packet decoder with an Avalon-MM register slave.
// Assumes the UDP layer delivers payload bytes with sop/eop and the port.
//
// Behaviour
// - Take packets on the configured port, or on 1025 when that is zero.
// - Byte 4 gives the number of converters fitted.
// - Byte 5 bits enable dither per converter, bit n for converter n.
// - Byte 6 bits enable the randomiser per converter.
// - Bytes 7 to 16 form the eighty channel enables, LSB first.
// - Byte 17 picks the converter feeding channel 0.
// - Source equal to converter count routes DAC data into that channel.
// - Bytes 18-19 give channel 0 rate in ksps, from a fixed set.
// - Decimation bytes 20 and 21 are reserved and ignored.
// - Byte 22 is channel 0 sample size, 24 bits by default.
// - Channels 1 to 79 follow as six-byte records up to byte 496.
// - Bytes 1363-1442 hold one grouping mask per channel.
// - Byte 1443 bit n marks channel n multiplexed rather than synchronised.
// - Synchronised members tune to the base channel frequency.
// - A zero grouping mask means no partners.
// - Synchronised count within converter count; multiplexed within channels (code flags only the synchronised count, over channels 0-7).
// - Only channels 0 and 1 synchronise, output at channel 0.
// - Only channels 0 and 1 multiplex, output at channel 0.
`timescale 1ns/1ps
module dcp_decoder import dcp_pkg::*; #(
  parameter int NCH = DCP_NCH
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [15:0] cfg_dest_port,
  input wire logic [15:0] pkt_dst_port,
  input wire logic pkt_valid,
  input wire dcp_byte_s pkt_byte,
  output logic [7:0] adc_count,
  output logic [7:0] dither_en,
  output logic [7:0] random_en,
  output logic [NCH-1:0] chan_en,
  output dcp_chan_s ch0_cfg,
  output dcp_chan_s ch1_cfg,
  output logic [NCH-1:0] ch_use_dac,
  output logic sync01_en,
  output logic mux01_en,
  output logic tune_ch1_from_ch0,
  output logic cfg_update,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  dcp_chan_s ch_cfg_r [NCH];
  logic [7:0] grp_r [NCH];
  logic [7:0] mux_r, adc_count_r, dither_r, random_r, rate_hi_r;
  logic [31:0] seq_r, rdata_r;
  logic [NCH-1:0] chan_en_r;
  logic in_pkt_r, ctrl_en_r, ack_r, cfg_update_r, sync01_r, mux01_r, sync_over_r;
  logic [10:0] idx_r;
  logic [6:0] rec_ch_r, ch_sel_r;
  logic [2:0] rec_fld_r, status_r;
  logic [15:0] pkt_cnt_r;

  // ----------------------------------------------------------------
  // Byte acceptance
  // ----------------------------------------------------------------
  logic [15:0] active_port, rate_word;
  logic port_ok, take, in_rec, in_grp, rate_ok;
  logic [10:0] cur_idx;
  logic [6:0] grp_ch, en_base;

  assign active_port = (cfg_dest_port == 16'h0000) ? DCP_DEF_PORT : cfg_dest_port;
  assign port_ok = ctrl_en_r && (pkt_dst_port == active_port);
  assign take = pkt_valid && (pkt_byte.sop ? port_ok : in_pkt_r);
  assign cur_idx = pkt_byte.sop ? 11'h000 : idx_r;
  assign in_rec = (cur_idx >= DCP_OFF_REC_FIRST) && (cur_idx <= DCP_OFF_REC_LAST);
  assign in_grp = (cur_idx >= DCP_OFF_GRP_FIRST) && (cur_idx <= DCP_OFF_GRP_LAST);
  assign grp_ch = 7'(cur_idx - DCP_OFF_GRP_FIRST);
  assign en_base = 7'((cur_idx - DCP_OFF_EN_FIRST) << 3);
  assign rate_word = {rate_hi_r, pkt_byte.data};

  dcp_rate_check u_rate (
    .rate(rate_word),
    .valid(rate_ok)
  );

  always_ff @(posedge clock) begin
    if (rst) begin
      in_pkt_r <= 1'b0;
      idx_r <= 11'h000;
    end else if (take) begin
      in_pkt_r <= !pkt_byte.eop;
      idx_r <= (cur_idx == DCP_IDX_MAX) ? cur_idx : 11'(cur_idx + 11'h001);
    end else if (pkt_valid && pkt_byte.sop) begin
      in_pkt_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Header fields
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      seq_r <= 32'h0000_0000;
      adc_count_r <= 8'h00;
      dither_r <= 8'h00;
      random_r <= 8'h00;
      chan_en_r <= '0;
      mux_r <= 8'h00;
    end else if (take) begin
      if (cur_idx <= DCP_OFF_SEQ_LAST) begin
        seq_r <= {seq_r[23:0], pkt_byte.data};
      end
      if (cur_idx == DCP_OFF_ADC_NUM) begin
        adc_count_r <= pkt_byte.data;
      end
      if (cur_idx == DCP_OFF_DITHER) begin
        dither_r <= pkt_byte.data;
      end
      if (cur_idx == DCP_OFF_RANDOM) begin
        random_r <= pkt_byte.data;
      end
      if (cur_idx >= DCP_OFF_EN_FIRST && cur_idx <= DCP_OFF_EN_LAST) begin
        chan_en_r[en_base +: 8] <= pkt_byte.data;
      end
      if (cur_idx == DCP_OFF_MUX) begin
        mux_r <= pkt_byte.data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Channel records
  // ----------------------------------------------------------------
  // Running record counters avoid a divide-by-six on the byte index.
  always_ff @(posedge clock) begin
    if (rst || (pkt_valid && pkt_byte.sop)) begin
      rec_ch_r <= 7'h00;
      rec_fld_r <= DCP_FLD_SRC;
    end else if (take && in_rec) begin
      if (rec_fld_r == DCP_FLD_SIZE) begin
        rec_fld_r <= DCP_FLD_SRC;
        rec_ch_r <= 7'(rec_ch_r + 7'h01);
      end else begin
        rec_fld_r <= 3'(rec_fld_r + 3'h1);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rate_hi_r <= 8'h00;
      for (int i = 0; i < NCH; i++) begin
        ch_cfg_r[i].source <= 8'h00;
        ch_cfg_r[i].rate <= DCP_DEF_RATE;
        ch_cfg_r[i].size <= DCP_DEF_SIZE;
      end
    end else if (take && in_rec) begin
      case (rec_fld_r)
        DCP_FLD_SRC: ch_cfg_r[rec_ch_r].source <= pkt_byte.data;
        DCP_FLD_RATE_HI: rate_hi_r <= pkt_byte.data;
        DCP_FLD_RATE_LO: ch_cfg_r[rec_ch_r].rate <= rate_word;
        DCP_FLD_SIZE: ch_cfg_r[rec_ch_r].size <= pkt_byte.data;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Grouping masks
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < NCH; i++) begin
        grp_r[i] <= 8'h00;
      end
    end else if (take && in_grp) begin
      grp_r[grp_ch] <= pkt_byte.data;
    end
  end

  // A zero mask leaves a channel on its own; only 0/1 pairing is built.
  logic sync_nxt, mux_nxt;
  logic [3:0] sync_cnt;
  always_comb begin
    sync_nxt = (grp_r[1][0] && !mux_r[1]) || (grp_r[0][1] && !mux_r[0]);
    mux_nxt = (grp_r[1][0] && mux_r[1]) || (grp_r[0][1] && mux_r[0]);
    sync_cnt = 4'h0;
    for (int i = 0; i < DCP_NGRP; i++) begin
      if ((grp_r[i] != 8'h00) && !mux_r[i]) begin
        sync_cnt = 4'(sync_cnt + 4'h1);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sync01_r <= 1'b0;
      mux01_r <= 1'b0;
      sync_over_r <= 1'b0;
    end else begin
      sync01_r <= sync_nxt;
      mux01_r <= mux_nxt;
      sync_over_r <= ({4'h0, sync_cnt} > adc_count_r);
    end
  end

  // DAC loopback per channel when its source equals the converter count
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_dac
      assign ch_use_dac[g] = (ch_cfg_r[g].source == adc_count_r);
    end
  endgenerate

  // ----------------------------------------------------------------
  // Status and packet counting
  // ----------------------------------------------------------------
  logic pkt_end, bus_wr;
  assign pkt_end = take && pkt_byte.eop;
  assign bus_wr = avs_write && ack_r;

  // Status bits are write-one-to-clear; a new event wins over the clear.
  always_ff @(posedge clock) begin
    if (rst) begin
      status_r <= 3'h0;
    end else begin
      if (bus_wr && avs_address == DCP_REG_STATUS) begin
        status_r <= status_r & ~avs_writedata[2:0];
      end
      if (take && in_rec && rec_fld_r == DCP_FLD_RATE_LO && !rate_ok) begin
        status_r[DCP_ST_BAD_RATE] <= 1'b1;
      end
      if (pkt_end && cur_idx < DCP_OFF_MUX) begin
        status_r[DCP_ST_SHORT] <= 1'b1;
      end
      if (sync_over_r) begin
        status_r[DCP_ST_SYNC_OVER] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pkt_cnt_r <= 16'h0000;
      cfg_update_r <= 1'b0;
    end else begin
      cfg_update_r <= pkt_end;
      if (pkt_end) begin
        pkt_cnt_r <= 16'(pkt_cnt_r + 16'h0001);
      end
    end
  end

  // ----------------------------------------------------------------
  // Avalon-MM slave, one wait cycle per access
  // ----------------------------------------------------------------
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read || avs_write) && !ack_r;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_en_r <= 1'b1;
      ch_sel_r <= 7'h00;
    end else if (bus_wr) begin
      if (avs_address == DCP_REG_CTRL) begin
        ctrl_en_r <= avs_writedata[0];
      end
      if (avs_address == DCP_REG_CH_SEL && avs_writedata[6:0] < 7'(NCH)) begin
        ch_sel_r <= avs_writedata[6:0];
      end
    end
  end

  logic [31:0] rdata_nxt;
  always_comb begin
    case (avs_address)
      DCP_REG_CTRL: rdata_nxt = {31'h0, ctrl_en_r};
      DCP_REG_STATUS: rdata_nxt = {pkt_cnt_r, 13'h0, status_r};
      DCP_REG_SEQ: rdata_nxt = seq_r;
      DCP_REG_CH_SEL: rdata_nxt = {25'h0, ch_sel_r};
      DCP_REG_CH_CFG: rdata_nxt = ch_cfg_r[ch_sel_r];
      DCP_REG_CH_GRP: rdata_nxt = {15'h0, chan_en_r[ch_sel_r], 7'h0,
                                   mux_r[ch_sel_r[2:0]], grp_r[ch_sel_r]};
      DCP_REG_GLOBAL: rdata_nxt = {8'h0, adc_count_r, dither_r, random_r};
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_r <= 32'h0000_0000;
    end else if (avs_read && !ack_r) begin
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign avs_readdata = rdata_r;
  assign adc_count = adc_count_r;
  assign dither_en = dither_r;
  assign random_en = random_r;
  assign chan_en = chan_en_r;
  assign ch0_cfg = ch_cfg_r[0];
  assign ch1_cfg = ch_cfg_r[1];
  assign sync01_en = sync01_r;
  assign mux01_en = mux01_r;
  assign tune_ch1_from_ch0 = sync01_r;
  assign cfg_update = cfg_update_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_DEF_PORT: assert property (@(posedge clock) disable iff (rst)
    pkt_valid && pkt_byte.sop && !pkt_byte.eop && ctrl_en_r &&
    cfg_dest_port == 16'h0000 && pkt_dst_port == DCP_DEF_PORT |=> in_pkt_r)
    else $error("default port packet not taken");
  AST_REJECT: assert property (@(posedge clock) disable iff (rst)
    pkt_valid && pkt_byte.sop && pkt_dst_port != active_port |=> !in_pkt_r && !cfg_update)
    else $error("foreign port packet taken");
  AST_SEQ: assert property (@(posedge clock) disable iff (rst)
    take && cur_idx == DCP_OFF_SEQ_LAST |=> seq_r[15:0] == {$past(seq_r[7:0]),
    $past(pkt_byte.data)})
    else $error("sequence number not big-endian");
  AST_ADC: assert property (@(posedge clock) disable iff (rst)
    take && cur_idx == DCP_OFF_ADC_NUM |=> adc_count == $past(pkt_byte.data))
    else $error("converter count not captured");
  AST_DITHER: assert property (@(posedge clock) disable iff (rst)
    take && cur_idx == DCP_OFF_DITHER |=> dither_en == $past(pkt_byte.data)
    && random_en == $past(random_r))
    else $error("dither byte misplaced");
  AST_RATE0: assert property (@(posedge clock) disable iff (rst)
    take && !pkt_byte.sop && idx_r == 11'h013 |=> ch0_cfg.rate ==
    {$past(rate_hi_r), $past(pkt_byte.data)})
    else $error("channel 0 rate wrong");
  // Checked one edge after each reset edge, so the first clock needs no history
  AST_SIZE_RST: assert property (@(posedge clock)
    rst |=> ch0_cfg.size == DCP_DEF_SIZE && ch1_cfg.size == DCP_DEF_SIZE)
    else $error("sample size default missing");
  AST_GRP: assert property (@(posedge clock) disable iff (rst)
    take && cur_idx == 11'h554 |=> grp_r[1] == $past(pkt_byte.data))
    else $error("grouping mask of channel 1 wrong");
  // Pair flags follow the masks one edge later
  AST_SYNC: assert property (@(posedge clock) disable iff (rst)
    grp_r[1] == 8'h01 && !mux_r[1] && grp_r[0] == 8'h00 |=> tune_ch1_from_ch0
    && !mux01_en)
    else $error("sync pair not formed");
  AST_WAIT: assert property (@(posedge clock) disable iff (rst)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("access not answered in one wait");

endmodule

/* File: verilog/dcp_pkg.sv */
// Shared constants and carriers for the channel configuration packet decoder.
// Assumes byte offsets count from the first byte of the UDP payload.
package dcp_pkg;

  // ----------------------------------------------------------------
  // Packet layout
  // ----------------------------------------------------------------
  localparam logic [15:0] DCP_DEF_PORT = 16'h0401;
  localparam logic [10:0] DCP_OFF_SEQ_LAST = 11'h003;
  localparam logic [10:0] DCP_OFF_ADC_NUM = 11'h004;
  localparam logic [10:0] DCP_OFF_DITHER = 11'h005;
  localparam logic [10:0] DCP_OFF_RANDOM = 11'h006;
  localparam logic [10:0] DCP_OFF_EN_FIRST = 11'h007;
  localparam logic [10:0] DCP_OFF_EN_LAST = 11'h010;
  localparam logic [10:0] DCP_OFF_REC_FIRST = 11'h011;
  localparam logic [10:0] DCP_OFF_REC_LAST = 11'h1F0;
  localparam logic [10:0] DCP_OFF_GRP_FIRST = 11'h553;
  localparam logic [10:0] DCP_OFF_GRP_LAST = 11'h5A2;
  localparam logic [10:0] DCP_OFF_MUX = 11'h5A3;
  localparam logic [10:0] DCP_IDX_MAX = 11'h7FF;

  // Six-byte channel record
  localparam logic [2:0] DCP_FLD_SRC = 3'h0;
  localparam logic [2:0] DCP_FLD_RATE_HI = 3'h1;
  localparam logic [2:0] DCP_FLD_RATE_LO = 3'h2;
  localparam logic [2:0] DCP_FLD_DEC1 = 3'h3;
  localparam logic [2:0] DCP_FLD_DEC2 = 3'h4;
  localparam logic [2:0] DCP_FLD_SIZE = 3'h5;

  localparam int DCP_NCH = 80;
  localparam int DCP_NGRP = 8;
  localparam logic [7:0] DCP_DEF_SIZE = 8'h18;

  // Accepted sampling rates in ksps
  localparam logic [15:0] DCP_RATE_48 = 16'h0030;
  localparam logic [15:0] DCP_RATE_96 = 16'h0060;
  localparam logic [15:0] DCP_RATE_192 = 16'h00C0;
  localparam logic [15:0] DCP_RATE_384 = 16'h0180;
  localparam logic [15:0] DCP_RATE_768 = 16'h0300;
  localparam logic [15:0] DCP_RATE_1536 = 16'h0600;
  localparam logic [15:0] DCP_DEF_RATE = DCP_RATE_48;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [4:0] DCP_REG_CTRL = 5'h00;
  localparam logic [4:0] DCP_REG_STATUS = 5'h04;
  localparam logic [4:0] DCP_REG_SEQ = 5'h08;
  localparam logic [4:0] DCP_REG_CH_SEL = 5'h0C;
  localparam logic [4:0] DCP_REG_CH_CFG = 5'h10;
  localparam logic [4:0] DCP_REG_CH_GRP = 5'h14;
  localparam logic [4:0] DCP_REG_GLOBAL = 5'h18;
  localparam int DCP_ST_BAD_RATE = 0;
  localparam int DCP_ST_SHORT = 1;
  localparam int DCP_ST_SYNC_OVER = 2;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sop;
    logic eop;
    logic [7:0] data;
  } dcp_byte_s;

  typedef struct packed {
    logic [7:0] source;
    logic [15:0] rate;
    logic [7:0] size;
  } dcp_chan_s;

endpackage

/* File: verilog/dcp_rate_check.sv */
// Checks a sampling rate word against the accepted set.
// Assumes a plain combinational use; no clock.
`timescale 1ns/1ps
module dcp_rate_check import dcp_pkg::*; (
  input wire logic [15:0] rate,
  output logic valid
);

  // ----------------------------------------------------------------
  // Rate lookup
  // ----------------------------------------------------------------
  always_comb begin
    case (rate)
      DCP_RATE_48, DCP_RATE_96, DCP_RATE_192,
      DCP_RATE_384, DCP_RATE_768, DCP_RATE_1536: valid = 1'b1;
      default: valid = 1'b0;
    endcase
  end

endmodule

/* File: bench/dcp_host_model.sv */
// Host program model: sends configuration packets byte by byte.
// Assumes the bench fills pkt[] and then calls send.
`timescale 1ns/1ps
module dcp_host_model import dcp_pkg::*; (
  input wire logic clock,
  output logic [15:0] pkt_dst_port,
  output logic pkt_valid,
  output dcp_byte_s pkt_byte
);
  logic [7:0] pkt [0:1443];

  initial begin
    pkt_dst_port = 16'h0000;
    pkt_valid = 1'b0;
    pkt_byte = '0;
  end

  // --------------------------------------------------------------
  // Packet sender
  // --------------------------------------------------------------
  // Idle gaps every 100 bytes; idle data is inverted so no stale byte looks valid
  task automatic send(input int len, input logic [15:0] port);
    for (int i = 0; i < len; i++) begin
      @(posedge clock);
      pkt_valid <= 1'b1;
      pkt_dst_port <= port;
      pkt_byte <= '{sop: (i == 0), eop: (i == len - 1), data: pkt[i]};
      if (i % 100 == 99) begin
        @(posedge clock);
        pkt_valid <= 1'b0;
        pkt_byte.data <= ~pkt[i];
      end
    end
    @(posedge clock);
    pkt_valid <= 1'b0;
    pkt_byte <= '{sop: 1'b0, eop: 1'b0, data: ~pkt[len - 1]};
  endtask
endmodule

/* File: bench/dcp_decoder_tb.sv */
// Self-checking bench for the configuration packet decoder.
// Assumes dcp_host_model as packet source and an Avalon-MM master here.
`timescale 1ns/1ps
module dcp_decoder_tb import dcp_pkg::*;;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [15:0] cfg_dest_port = 16'h0000;
  logic [15:0] pkt_dst_port;
  logic pkt_valid;
  dcp_byte_s pkt_byte;
  logic [7:0] adc_count, dither_en, random_en;
  logic [79:0] chan_en, ch_use_dac, exp_en, exp_dac;
  dcp_chan_s ch0_cfg, ch1_cfg;
  logic sync01_en, mux01_en, tune_ch1_from_ch0, cfg_update;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  int updates = 0;

  always #2.5 clock = ~clock;

  dcp_decoder i_dcp_decoder (.clock, .rst, .cfg_dest_port, .pkt_dst_port, .pkt_valid,
    .pkt_byte, .adc_count, .dither_en, .random_en, .chan_en, .ch0_cfg, .ch1_cfg,
    .ch_use_dac, .sync01_en, .mux01_en, .tune_ch1_from_ch0, .cfg_update, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);
  dcp_host_model i_dcp_host_model (.clock, .pkt_dst_port, .pkt_valid, .pkt_byte);

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic complete_run;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cfg_update === 1'b1) begin
      updates++;
    end
    if (cycles == 20000) begin
      miscompares++;
      complete_run();
    end
  end

  task automatic chk(input string name, input logic [79:0] seen, input logic [79:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Bus cycle: held until waitrequest is sampled low; only the cycle ceiling ends a hang
  task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= d;
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // Grouped channels share one rate; channel 1 left disabled as it is attached
  task automatic build(input logic [7:0] adc, input logic [7:0] src0, input logic [7:0] m0,
    input logic [7:0] m1, input logic [7:0] mux);
    for (int i = 0; i < 1444; i++) begin
      i_dcp_host_model.pkt[i] = 8'h00;
    end
    i_dcp_host_model.pkt[4] = adc;
    i_dcp_host_model.pkt[5] = 8'h05;
    i_dcp_host_model.pkt[6] = 8'h0A;
    for (int k = 0; k < 10; k++) begin
      i_dcp_host_model.pkt[7 + k] = 8'hA5 + 8'(k);
      exp_en[k * 8 +: 8] = 8'hA5 + 8'(k);
    end
    for (int k = 0; k < 80; k++) begin
      i_dcp_host_model.pkt[17 + 6 * k] = (k == 0) ? src0 : 8'(k % 3);
      i_dcp_host_model.pkt[19 + 6 * k] = 8'h60;
      i_dcp_host_model.pkt[20 + 6 * k] = 8'hFF;
      i_dcp_host_model.pkt[21 + 6 * k] = 8'hFF;
      i_dcp_host_model.pkt[22 + 6 * k] = (k == 0) ? 8'h20 : 8'h10;
      exp_dac[k] = (i_dcp_host_model.pkt[17 + 6 * k] == adc);
    end
    i_dcp_host_model.pkt[1363] = m0;
    i_dcp_host_model.pkt[1364] = m1;
    i_dcp_host_model.pkt[1443] = mux;
  endtask

  task automatic chk_cfg(input logic [7:0] adc, input logic [7:0] src0, input logic s,
    input logic m);
    repeat (3) @(posedge clock);
    #1;
    chk("adc_count", adc_count, adc);
    chk("dither_en", dither_en, 8'h05);
    chk("random_en", random_en, 8'h0A);
    chk("chan_en", chan_en, exp_en);
    chk("ch0_cfg", ch0_cfg, {src0, 16'h0060, 8'h20});
    chk("ch1_cfg", ch1_cfg, {8'h01, 16'h0060, 8'h10});
    chk("ch_use_dac", ch_use_dac, exp_dac);
    chk("sync01_en", sync01_en, s);
    chk("mux01_en", mux01_en, m);
    chk("tune", tune_ch1_from_ch0, s);
  endtask

  // --------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    av(1'b0, DCP_REG_CTRL, 32'h0);
    chk("ctrl", rd, 32'h1);
    av(1'b0, DCP_REG_CH_CFG, 32'h0);
    chk("ch_cfg reset", rd, 32'h0000_3018);
    av(1'b0, 5'h1C, 32'h0);
    chk("unmapped", rd, 32'h0);
    $display("test reset done");
    build(8'h02, 8'h02, 8'h00, 8'h01, 8'h00);
    i_dcp_host_model.send(1444, 16'h0401);
    chk_cfg(8'h02, 8'h02, 1'b1, 1'b0);
    chk("updates", updates, 1);
    av(1'b0, DCP_REG_STATUS, 32'h0);
    chk("status", rd, 32'h0001_0000);
    av(1'b1, DCP_REG_CH_SEL, 32'h4F);
    av(1'b1, DCP_REG_CH_SEL, 32'h50);
    av(1'b0, DCP_REG_CH_SEL, 32'h0);
    chk("ch_sel", rd[6:0], 7'h4F);
    av(1'b0, DCP_REG_CH_CFG, 32'h0);
    chk("ch79", rd, 32'h0100_6010);
    av(1'b0, DCP_REG_GLOBAL, 32'h0);
    chk("global", rd, 32'h0002_050A);
    av(1'b0, DCP_REG_SEQ, 32'h0);
    chk("seq", rd, 32'h0);
    av(1'b1, DCP_REG_CH_SEL, 32'h1);
    av(1'b0, DCP_REG_CH_GRP, 32'h0);
    chk("ch_grp", rd, 32'h0000_0001);
    $display("test full packet done");
    build(8'h07, 8'h02, 8'h00, 8'h01, 8'h00);
    i_dcp_host_model.send(1444, 16'h0402);
    repeat (3) @(posedge clock);
    chk("wrong port", adc_count, 8'h02);
    chk("updates", updates, 1);
    cfg_dest_port <= 16'h1388;
    build(8'h01, 8'h01, 8'h00, 8'h01, 8'h02);
    i_dcp_host_model.send(1444, 16'h1388);
    chk_cfg(8'h01, 8'h01, 1'b0, 1'b1);
    build(8'h00, 8'h00, 8'h02, 8'h00, 8'h00);
    i_dcp_host_model.send(1444, 16'h1388);
    chk_cfg(8'h00, 8'h00, 1'b1, 1'b0);
    av(1'b0, DCP_REG_STATUS, 32'h0);
    chk("sync over", rd, 32'h0003_0004);
    $display("test port and grouping done");
    av(1'b1, DCP_REG_STATUS, 32'h7);
    for (int r = 0; r < 7; r++) begin
      logic [15:0] rate;
      rate = (r == 6) ? 16'h0031 : (16'h0030 << r);
      i_dcp_host_model.pkt[18] = rate[15:8];
      i_dcp_host_model.pkt[19] = rate[7:0];
      i_dcp_host_model.send(23, 16'h1388);
      repeat (2) @(posedge clock);
      #1;
      chk("rate", ch0_cfg.rate, rate);
      av(1'b0, DCP_REG_STATUS, 32'h0);
      chk("bad rate", rd[0], (r == 6));
    end
    av(1'b1, DCP_REG_STATUS, 32'h1);
    av(1'b0, DCP_REG_STATUS, 32'h0);
    chk("status w1c", rd[2:0], 3'b110);
    $display("test rates done");
    av(1'b1, DCP_REG_CTRL, 32'h0);
    i_dcp_host_model.pkt[4] = 8'h09;
    i_dcp_host_model.send(23, 16'h1388);
    repeat (3) @(posedge clock);
    chk("disabled", adc_count, 8'h00);
    chk("updates", updates, 10);
    av(1'b1, DCP_REG_CTRL, 32'h1);
    $display("test accept disable done");
    complete_run();
  end
endmodule
